/* core/dll_switch_defs.svh */
// Constants for the DLL on/off mode switch logic inside the memory device.
// Assumes inclusion by the package and design files by bare name.
`ifndef DLL_SWITCH_DEFS_SVH
`define DLL_SWITCH_DEFS_SVH
`define DLLSW_DLL_OFF_BIT 0
`define DLLSW_DLL_RESET_BIT 8
`define DLLSW_OFF_CAS_LATENCY 4'h6
`define DLLSW_OFF_CAS_WRITE_LATENCY 4'h6
`define DLLSW_MRD_CYCLES 4
`define DLLSW_MOD_NS 15
`define DLLSW_MOD_MIN_CYCLES 12
`define DLLSW_XS_NS 170
`define DLLSW_DLLK_CYCLES 512
`define DLLSW_ZQOPER_CYCLES 256
`define DLLSW_PERIOD_PS 5000
`endif

/* core/dll_switch_pkg.sv */
// Types for the DLL on/off mode switch logic.
// Assumes the defs header is on the include path.
`include "dll_switch_defs.svh"
package dll_switch_pkg;
	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_MRS,
		CMD_SRE,
		CMD_SRX,
		CMD_LONG_CAL,
		CMD_READ,
		CMD_OTHER
	} cmd_e;
	typedef struct packed {
		cmd_e cmd;
		logic [2:0] bank;
		logic [15:0] addr;
	} cmd_s;
	typedef enum logic [1:0] {
		WAIT_MOD,
		WAIT_MRD,
		WAIT_XS,
		WAIT_DLLK
	} wait_e;
endpackage

/* core/wait_counter.sv */
// Down-counter that holds off a class of commands for a loaded cycle count.
// Assumes one clock and asynchronous active-low reset.
`timescale 1ns/1ps
module wait_counter #(
	parameter int WIDTH = 10
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_count,
	output logic o_busy
);
	logic [WIDTH-1:0] remain;
	wire logic [WIDTH-1:0] next_remain = i_load ? i_count :
		(remain != '0) ? remain - {{(WIDTH-1){1'b0}}, 1'b1} : remain;

	if (WIDTH < 2) begin : g_bad_width
		$error("wait_counter WIDTH too small");
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) remain <= '0;
		else remain <= next_remain;
	end

	// Counted one edge short so the command on the final edge is accepted
	assign o_busy = (remain > {{(WIDTH-1){1'b0}}, 1'b1});
endmodule

/* core/dll_mode_switch.sv */
// DLL on/off mode tracking inside the memory device: mode-register writes,
// self refresh entry/exit, DLL reset and lock, and command acceptance gating.
// Assumes commands arrive one per clock edge, already decoded and synchronous.
`timescale 1ns/1ps
`include "dll_switch_defs.svh"

// What this block does
// - mode_reg_1 bit A0 high disables the loop
// - next command accepted after final mode wait
// - cycle waits count actual clock edges
// - nanosecond waits round up to whole cycles
// - loop-off supports latency six, write six
// - loop-off read strobe starts one cycle earlier
module dll_mode_switch #(
	parameter int DLLK_CYCLES = `DLLSW_DLLK_CYCLES,
	parameter int ZQOPER_CYCLES = `DLLSW_ZQOPER_CYCLES,
	parameter int CNT_WIDTH = 12
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire dll_switch_pkg::cmd_s i_cmd,
	input wire logic i_clock_enable_pin,
	input wire logic i_term_enable_pin,
	input wire logic [3:0] i_additive_latency,
	output logic o_dll_off,
	output logic o_dll_locked,
	output logic o_self_refresh,
	output logic o_cmd_ready,
	output logic o_locked_cmd_ready,
	output logic [3:0] o_cas_latency,
	output logic [3:0] o_cas_write_latency,
	output logic o_latency_error,
	output logic o_protocol_error,
	output logic [4:0] o_read_strobe_delay
);
	import dll_switch_pkg::*;

	localparam int MOD_NS_CYC = (`DLLSW_MOD_NS * 1000 + `DLLSW_PERIOD_PS - 1)
		/ `DLLSW_PERIOD_PS;
	localparam int MOD_CYCLES = (MOD_NS_CYC > `DLLSW_MOD_MIN_CYCLES) ?
		MOD_NS_CYC : `DLLSW_MOD_MIN_CYCLES;
	localparam int XS_CYCLES = (`DLLSW_XS_NS * 1000 + `DLLSW_PERIOD_PS - 1)
		/ `DLLSW_PERIOD_PS;
	localparam int WAIT_CAL = 4;
	localparam int NWAIT = 5;

	// Every wait count must fit the down-counters and be at least one edge
	if (DLLK_CYCLES >= (1 << CNT_WIDTH)) begin : g_bad_lock_count
		$error("dll_mode_switch DLLK_CYCLES does not fit CNT_WIDTH");
	end
	if (ZQOPER_CYCLES >= (1 << CNT_WIDTH)) begin : g_bad_cal_count
		$error("dll_mode_switch ZQOPER_CYCLES does not fit CNT_WIDTH");
	end
	if (MOD_CYCLES >= (1 << CNT_WIDTH)) begin : g_bad_mode_count
		$error("dll_mode_switch CNT_WIDTH too small for the mode wait");
	end
	if (XS_CYCLES >= (1 << CNT_WIDTH)) begin : g_bad_exit_count
		$error("dll_mode_switch CNT_WIDTH too small for the exit wait");
	end
	if (DLLK_CYCLES < 1 || ZQOPER_CYCLES < 1) begin : g_bad_zero_count
		$error("dll_mode_switch wait counts must be at least one");
	end

	logic dll_off;
	logic [3:0] cas_latency;
	logic [3:0] cas_write_latency;
	logic self_refresh;
	logic term_on_at_entry;
	logic lock_pending;
	logic await_reset;
	logic protocol_error;
	logic [4:0] read_strobe_delay;

	wire logic is_mrs = (i_cmd.cmd == CMD_MRS);
	wire logic mode0_write = is_mrs && (i_cmd.bank == 3'h0);
	wire logic mode1_write = is_mrs && (i_cmd.bank == 3'h1);
	wire logic mode2_write = is_mrs && (i_cmd.bank == 3'h2);
	wire logic dll_reset_write = mode0_write && i_cmd.addr[`DLLSW_DLL_RESET_BIT];
	wire logic loop_enable_write = mode1_write && !i_cmd.addr[`DLLSW_DLL_OFF_BIT] && dll_off;
	wire logic sr_entry = (i_cmd.cmd == CMD_SRE);
	wire logic sr_exit = (i_cmd.cmd == CMD_SRX) && self_refresh;
	wire logic zq_cmd = (i_cmd.cmd == CMD_LONG_CAL);
	wire logic read_cmd = (i_cmd.cmd == CMD_READ);
	wire logic active_cmd = (i_cmd.cmd != CMD_NOP);

	// One down-counter per named wait, counting real clock edges
	logic [NWAIT-1:0] wait_load;
	logic [NWAIT-1:0] wait_busy;
	logic [CNT_WIDTH-1:0] wait_count [NWAIT];
	assign wait_load[WAIT_MOD] = is_mrs;
	assign wait_load[WAIT_MRD] = is_mrs;
	assign wait_load[WAIT_XS] = sr_exit;
	assign wait_load[WAIT_DLLK] = dll_reset_write;
	// Calibration has its own counter so it never cuts a running lock wait short
	assign wait_load[WAIT_CAL] = zq_cmd && !self_refresh;
	assign wait_count[WAIT_MOD] = CNT_WIDTH'(MOD_CYCLES);
	assign wait_count[WAIT_MRD] = CNT_WIDTH'(`DLLSW_MRD_CYCLES);
	assign wait_count[WAIT_XS] = CNT_WIDTH'(XS_CYCLES);
	assign wait_count[WAIT_DLLK] = CNT_WIDTH'(DLLK_CYCLES);
	assign wait_count[WAIT_CAL] = CNT_WIDTH'(ZQOPER_CYCLES);

	for (genvar w = 0; w < NWAIT; w++) begin : g_wait
		wait_counter #(
			.WIDTH(CNT_WIDTH)
		) u_wait (
			.i_ref_clk(i_ref_clk),
			.i_arst_n(i_arst_n),
			.i_load(wait_load[w]),
			.i_count(wait_count[w]),
			.o_busy(wait_busy[w])
		);
	end

	// Outside self refresh, commands are accepted once the mode and exit waits are over; loop-on reads also need lock
	wire logic mod_done = !wait_busy[WAIT_MOD] && !wait_busy[WAIT_MRD];
	wire logic next_cmd_ready = mod_done && !wait_busy[WAIT_XS] && !self_refresh;
	wire logic mrs_allowed = !wait_busy[WAIT_MRD] && !wait_busy[WAIT_XS];
	wire logic locked_ready = next_cmd_ready && !dll_off && !wait_busy[WAIT_DLLK] &&
		!wait_busy[WAIT_CAL] && !lock_pending;

	// Pin holds after exit: clock enable high, termination low if it was on
	wire logic hold_window = !self_refresh && (!mod_done || lock_pending || wait_busy[WAIT_XS]);
	wire logic cke_violation = hold_window && !i_clock_enable_pin;
	wire logic term_violation = hold_window && term_on_at_entry && i_term_enable_pin;
	wire logic early_mrs = is_mrs && !mrs_allowed;
	wire logic early_cmd = active_cmd && !is_mrs && !next_cmd_ready && !sr_exit &&
		!(zq_cmd && mod_done && !self_refresh);
	// A loop-on read needs the loop locked and any calibration finished
	wire logic early_read = read_cmd && !dll_off && (lock_pending ||
		wait_busy[WAIT_DLLK] || wait_busy[WAIT_CAL]);
	// Entry while already in self refresh, or exit outside it
	wire logic bad_sr = (sr_entry && self_refresh) || ((i_cmd.cmd == CMD_SRX) && !self_refresh);
	wire logic next_protocol_error = cke_violation || term_violation || early_mrs || early_cmd ||
		early_read || bad_sr;

	// Loop-off read strobe begins one cycle before the usual latency point
	wire logic [4:0] lat_sum = 5'(i_additive_latency) + 5'(cas_latency);
	wire logic [4:0] next_strobe = dll_off ? lat_sum - 5'h01 : lat_sum;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dll_off <= 1'b0;
		end else if (mode1_write) begin
			dll_off <= i_cmd.addr[`DLLSW_DLL_OFF_BIT];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cas_latency <= `DLLSW_OFF_CAS_LATENCY;
			cas_write_latency <= `DLLSW_OFF_CAS_WRITE_LATENCY;
		end else begin
			if (mode0_write) cas_latency <= i_cmd.addr[7:4];
			if (mode2_write) cas_write_latency <= i_cmd.addr[6:3];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			self_refresh <= 1'b0;
			term_on_at_entry <= 1'b0;
		end else if (sr_entry && !self_refresh) begin
			self_refresh <= 1'b1;
			term_on_at_entry <= i_term_enable_pin;
		end else if (sr_exit) begin
			self_refresh <= 1'b0;
		end
	end

	// Lock is pending from loop enable or a loop reset until the lock wait after a loop reset ends;
	// after a loop enable, without that reset the loop is never reported locked
	wire logic lock_done = lock_pending && !await_reset && !wait_busy[WAIT_DLLK] &&
		!wait_load[WAIT_DLLK] && !self_refresh && mod_done;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lock_pending <= 1'b0;
		end else if (loop_enable_write || dll_reset_write) begin
			lock_pending <= 1'b1;
		end else if (lock_done) begin
			lock_pending <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			await_reset <= 1'b0;
		end else if (loop_enable_write) begin
			await_reset <= 1'b1;
		end else if (dll_reset_write) begin
			await_reset <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			protocol_error <= 1'b0;
			read_strobe_delay <= 5'h00;
		end else begin
			protocol_error <= protocol_error || next_protocol_error;
			read_strobe_delay <= next_strobe;
		end
	end

	assign o_dll_off = dll_off;
	assign o_dll_locked = !dll_off && !lock_pending && !wait_busy[WAIT_DLLK];
	assign o_self_refresh = self_refresh;
	assign o_cmd_ready = next_cmd_ready;
	assign o_locked_cmd_ready = locked_ready;
	assign o_cas_latency = cas_latency;
	assign o_cas_write_latency = cas_write_latency;
	// Loop-off mode only serves latency six / write latency six
	assign o_latency_error = dll_off && ((cas_latency != `DLLSW_OFF_CAS_LATENCY) ||
		(cas_write_latency != `DLLSW_OFF_CAS_WRITE_LATENCY));
	assign o_protocol_error = protocol_error;
	assign o_read_strobe_delay = read_strobe_delay;
endmodule

/* sim/dll_mode_switch_sva.sv */
// Checker for the DLL mode switch ports.
// Assumes it is bound to every dll_mode_switch instance.
`timescale 1ns/1ps
module dll_mode_switch_sva #(
	parameter int DLLK_CYCLES = 512,
	parameter int ZQOPER_CYCLES = 256
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire dll_switch_pkg::cmd_s i_cmd,
	input wire logic i_clock_enable_pin,
	input wire logic i_term_enable_pin,
	input wire logic [3:0] i_additive_latency,
	input wire logic o_dll_off,
	input wire logic o_dll_locked,
	input wire logic o_self_refresh,
	input wire logic o_cmd_ready,
	input wire logic o_locked_cmd_ready,
	input wire logic [3:0] o_cas_latency,
	input wire logic [3:0] o_cas_write_latency,
	input wire logic o_latency_error,
	input wire logic o_protocol_error,
	input wire logic [4:0] o_read_strobe_delay
);
	import dll_switch_pkg::*;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	wire logic mrs = i_cmd.cmd == CMD_MRS;
	sequence mrs_close;
		mrs ##1 !mrs [*2] ##1 mrs;
	endsequence
	dll_off_set_a: assert property (mrs && i_cmd.bank == 3'h1 && i_cmd.addr[0] |=> o_dll_off)
		else $error("loop not disabled");
	dll_off_clr_a: assert property (mrs && i_cmd.bank == 3'h1 && !i_cmd.addr[0] |=> !o_dll_off)
		else $error("loop not enabled");
	mod_hold_a: assert property (mrs |=> !o_cmd_ready [*8])
		else $error("ready too early after mode write");
	mrs_space_a: assert property (mrs_close |=> o_protocol_error)
		else $error("close mode writes not flagged");
	sr_entry_a: assert property (i_cmd.cmd == CMD_SRE |=> o_self_refresh && !o_cmd_ready)
		else $error("self refresh not entered");
	sr_exit_a: assert property (i_cmd.cmd == CMD_SRX |=> !o_self_refresh ##0 !o_cmd_ready [*8])
		else $error("exit wait not kept");
	dll_reset_a: assert property (mrs && i_cmd.bank == 3'h0 && i_cmd.addr[8] |=>
		!(o_dll_locked || o_locked_cmd_ready) [*8]) else $error("lock claimed too early");
	latency_a: assert property (o_latency_error == (o_dll_off &&
		(o_cas_latency != 4'h6 || o_cas_write_latency != 4'h6))) else $error("latency flag wrong");
	strobe_a: assert property ($past(i_arst_n) |-> o_read_strobe_delay ==
		5'($past(i_additive_latency)) + 5'($past(o_cas_latency)) - 5'($past(o_dll_off)))
		else $error("strobe delay wrong");
endmodule
bind dll_mode_switch dll_mode_switch_sva #(.DLLK_CYCLES(DLLK_CYCLES),
	.ZQOPER_CYCLES(ZQOPER_CYCLES)) dll_mode_switch_sva_inst (.*);

/* sim/dram_ctrl_model.sv */
// Controller model issuing the DLL on/off switch command sequences.
// Assumes the bench calls its tasks; outputs feed the device inputs.
`timescale 1ns/1ps
`include "dll_switch_defs.svh"
module dram_ctrl_model (
	input wire logic i_ref_clk,
	output dll_switch_pkg::cmd_s o_cmd,
	output logic o_cke,
	output logic o_term
);
	import dll_switch_pkg::*;
	localparam int P = `DLLSW_PERIOD_PS;
	localparam int XS = (`DLLSW_XS_NS * 1000 + P - 1) / P;
	localparam int MODNS = (`DLLSW_MOD_NS * 1000 + P - 1) / P;
	localparam int MOD = MODNS > `DLLSW_MOD_MIN_CYCLES ? MODNS : `DLLSW_MOD_MIN_CYCLES;
	localparam int MRD = `DLLSW_MRD_CYCLES;
	initial begin
		o_cmd = '{CMD_NOP, 3'h0, 16'h0};
		o_cke = 1'b1;
		o_term = 1'b0;
	end
	// Pin levels change just after an edge
	task automatic set_pins(input logic cke, input logic term);
		@(posedge i_ref_clk) #1;
		o_cke = cke;
		o_term = term;
	endtask
	// Next command lands no earlier than gap edges later
	task automatic issue(input cmd_e c, input logic [2:0] b, input logic [15:0] a, input int gap);
		@(posedge i_ref_clk) #1;
		o_cmd = '{c, b, a};
		o_cke = c == CMD_SRE ? 1'b0 : c == CMD_SRX ? 1'b1 : o_cke;
		@(posedge i_ref_clk) #1;
		o_cmd = '{CMD_NOP, 3'h0, ~a};
		repeat (gap - 2) @(posedge i_ref_clk);
	endtask
	task automatic dll_off_seq(input logic [3:0] lat);
		issue(CMD_MRS, 3'h1, 16'h0001, MOD);
		issue(CMD_SRE, 3'h0, 16'h0, 8);
		issue(CMD_SRX, 3'h0, 16'h0, XS);
		issue(CMD_MRS, 3'h0, {8'h0, lat, 4'h0}, MRD);
		issue(CMD_MRS, 3'h2, 16'h0030, MOD);
	endtask
	task automatic dll_on_seq;
		issue(CMD_SRE, 3'h0, 16'h0, 8);
		issue(CMD_SRX, 3'h0, 16'h0, XS);
		issue(CMD_MRS, 3'h1, 16'h0000, MRD);
		issue(CMD_MRS, 3'h0, 16'h0160, MRD);
		issue(CMD_MRS, 3'h2, 16'h0030, MOD);
	endtask
endmodule

/* sim/dll_mode_switch_tb.sv */
// Self-checking bench for the DLL mode switch logic.
// Assumes the controller model and the checker compile alongside.
`timescale 1ns/1ps
module dll_mode_switch_tb;
	import dll_switch_pkg::*;
	localparam int DLLK = 40;
	localparam int ZQ = 24;
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [3:0] al = 4'h0;
	logic [15:0] lfsr = 16'h1;
	int errors = 0;
	int compares = 0;
	cmd_s cmd;
	logic cke, term, dll_off, locked, sr, rdy, lrdy, lat_err, perr;
	logic [3:0] cas_lat, cas_wlat;
	logic [4:0] strobe;
	always #2.5 i_ref_clk = ~i_ref_clk;
	dram_ctrl_model dram_ctrl_model_inst (.i_ref_clk(i_ref_clk), .o_cmd(cmd), .o_cke(cke),
		.o_term(term));
	dll_mode_switch #(.DLLK_CYCLES(DLLK), .ZQOPER_CYCLES(ZQ)) dll_mode_switch_inst (
		.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_cmd(cmd), .i_clock_enable_pin(cke),
		.i_term_enable_pin(term), .i_additive_latency(al), .o_dll_off(dll_off),
		.o_dll_locked(locked), .o_self_refresh(sr), .o_cmd_ready(rdy),
		.o_locked_cmd_ready(lrdy), .o_cas_latency(cas_lat), .o_cas_write_latency(cas_wlat),
		.o_latency_error(lat_err), .o_protocol_error(perr), .o_read_strobe_delay(strobe));
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [4:0] exp_strobe(input logic [3:0] a, input logic off);
		return 5'(a) + 5'h6 - 5'(off);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	// Mid-run reset: the sticky error, loop-off and self refresh flags must clear and ready must return
	task automatic restart;
		@(posedge i_ref_clk) #1;
		i_arst_n = 1'b0;
		settle(2);
		chk({perr, dll_off, sr, rdy}, 16'h1);
		i_arst_n = 1'b1;
	endtask
	task automatic strobe_rounds(input logic off);
		for (int i = 0; i < 6; i++) begin
			lfsr = next_rand(lfsr);
			@(posedge i_ref_clk) #1;
			al = i == 0 ? 4'hf : lfsr[3:0];
			settle(1);
			chk(strobe, exp_strobe(al, off));
		end
	endtask
	initial begin
		repeat (5000) @(posedge i_ref_clk);
		errors++;
		tally_and_finish;
	end
	initial begin
		settle(16);
		chk({cas_lat, cas_wlat, 3'h0, strobe}, 16'h6600);
		chk({sr, dll_off, lat_err, perr, rdy}, 16'h1);
		i_arst_n = 1'b1;
		strobe_rounds(1'b0);
		dram_ctrl_model_inst.dll_off_seq(4'h6);
		settle(2);
		chk({dll_off, sr, rdy, lat_err, perr}, 16'h14);
		dram_ctrl_model_inst.issue(CMD_MRS, 3'h0, 16'h0070, 12);
		settle(2);
		chk({cas_lat, lat_err}, 16'hf);
		dram_ctrl_model_inst.issue(CMD_MRS, 3'h0, 16'h0060, 12);
		settle(2);
		chk({cas_lat, lat_err}, 16'hc);
		strobe_rounds(1'b1);
		dram_ctrl_model_inst.dll_on_seq;
		settle(2);
		chk({dll_off, locked, lrdy, rdy}, 16'h1);
		settle(DLLK);
		chk({locked, lrdy, perr}, 16'h6);
		dram_ctrl_model_inst.issue(CMD_LONG_CAL, 3'h0, 16'h0, 12);
		settle(2);
		chk(lrdy, 16'h0);
		settle(ZQ);
		chk(lrdy, 16'h1);
		strobe_rounds(1'b0);
		dram_ctrl_model_inst.issue(CMD_MRS, 3'h2, 16'h0030, 3);
		dram_ctrl_model_inst.issue(CMD_MRS, 3'h2, 16'h0030, 12);
		settle(2);
		chk(perr, 16'h1);
		restart;
		dram_ctrl_model_inst.issue(CMD_MRS, 3'h2, 16'h0030, 4);
		dram_ctrl_model_inst.set_pins(1'b0, 1'b0);
		settle(2);
		chk(perr, 16'h1);
		restart;
		dram_ctrl_model_inst.set_pins(1'b1, 1'b1);
		dram_ctrl_model_inst.issue(CMD_SRE, 3'h0, 16'h0, 8);
		dram_ctrl_model_inst.issue(CMD_SRX, 3'h0, 16'h0, 4);
		settle(2);
		chk(perr, 16'h1);
		restart;
		dram_ctrl_model_inst.issue(CMD_MRS, 3'h0, 16'h0160, 12);
		dram_ctrl_model_inst.issue(CMD_READ, 3'h0, 16'h0, 4);
		settle(2);
		chk({locked, perr}, 16'h1);
		tally_and_finish;
	end
endmodule
